// ==== logic/perfmon_pkg.sv ====
// Constants, types and register map of the monitoring front end
`default_nettype none
package perfmon_pkg;
    localparam int NUM_CNT = 4;
    localparam int CNT_W = 32;
    localparam int NUM_CAT = 5;
    localparam int EVT_W = 8;
    localparam int ADDR_W = 8;

    // Byte offsets
    localparam logic [7:0] OFF_PERF_CAPABILITY_REG = 8'h00;
    localparam logic [7:0] OFF_EVCAP0 = 8'h10;
    localparam logic [7:0] OFF_CNTCAP0 = 8'h40;
    localparam logic [7:0] OFF_CFG0 = 8'h60;
    localparam logic [7:0] OFF_FLT0 = 8'h80;
    localparam logic [7:0] OFF_DATA0 = 8'hA0;

    // Capability field positions
    localparam int CAP_NCNT_LSB = 0;
    localparam int CAP_WIDTH_LSB = 8;
    localparam int CAP_PERCNT_BIT = 16;
    localparam int CAP_FLT_BIT = 17;
    localparam int CAP_CAT_LSB = 20;

    // Counter config field positions
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_CAT_LSB = 8;
    localparam int CFG_EVT_LSB = 16;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] FLT_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        CAT_WQ = 4'h0,
        CAT_ENGINE = 4'h1,
        CAT_XLATE = 4'h2,
        CAT_OPS = 4'h3,
        CAT_COMPL = 4'h4
    } event_cat_t;

    typedef struct packed {
        logic en;
        logic [3:0] cat;
        logic [EVT_W-1:0] evt;
    } cnt_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage
`default_nettype wire

// ==== logic/event_adder.sv ====
// Population count of the qualified events of one counter
`timescale 1ns/10ps
`default_nettype none
module event_adder (
    input wire logic [perfmon_pkg::EVT_W-1:0] hits,
    output logic [3:0] sum
);
    always_comb begin
        sum = 4'h0;
        for (int i = 0; i < perfmon_pkg::EVT_W; i++) begin
            sum = sum + {3'h0, hits[i]};
        end
    end
endmodule
`default_nettype wire

// ==== logic/perfmon_event_discovery.sv ====
// Capability, configuration and counting core of the monitoring block
`timescale 1ns/10ps
`default_nettype none
module perfmon_event_discovery #(
    parameter bit PRESENT = 1'b1,
    parameter bit FILTER_SUP = 1'b1,
    parameter logic [39:0] EVCAP = 40'h00_0F_07_3F_FF,
    parameter logic [31:0] CNTCAP_MASK = 32'h0000_001F
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [perfmon_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [perfmon_pkg::NUM_CAT*perfmon_pkg::EVT_W-1:0] events
);
    localparam int N = perfmon_pkg::NUM_CNT;
    localparam int EW = perfmon_pkg::EVT_W;
    localparam perfmon_pkg::cnt_cfg_t CFG_INIT = '{
        en: perfmon_pkg::CFG_RESET[perfmon_pkg::CFG_EN_BIT],
        cat: perfmon_pkg::CFG_RESET[perfmon_pkg::CFG_CAT_LSB +: 4],
        evt: perfmon_pkg::CFG_RESET[perfmon_pkg::CFG_EVT_LSB +: EW]
    };

    ////////////////////////////////////////////////////////////////////////
    perfmon_pkg::reg_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Event supported mask for a category; reserved codes give none
    function automatic logic [EW-1:0] cat_mask(input logic [3:0] cat);
        logic [EW-1:0] m;
        m = '0;
        if (cat < 4'(perfmon_pkg::NUM_CAT)) begin
            m = EVCAP[cat*EW +: EW];
        end
        return m;
    endfunction

    // Index of a per-counter register, or N if not hit
    function automatic int unsigned reg_idx(input logic [7:0] a,
                                           input logic [7:0] base);
        int unsigned r;
        r = N;
        if (a >= base && a < base + 8'(4 * N) && a[1:0] == 2'b00) begin
            r = int'(a - base) >> 2;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    perfmon_pkg::cnt_cfg_t cfg_q [N];
    perfmon_pkg::cnt_cfg_t cfg_d [N];
    logic [31:0] flt_q [N];
    logic [31:0] flt_d [N];
    logic [perfmon_pkg::CNT_W-1:0] cnt_q [N];
    logic [perfmon_pkg::CNT_W-1:0] cnt_d [N];
    logic [3:0] inc [N];
    logic [EW-1:0] hits [N];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cnt
            always_comb begin
                hits[g] = '0;
                if (cfg_q[g].en
                    && cfg_q[g].cat < 4'(perfmon_pkg::NUM_CAT)) begin
                    hits[g] = cfg_q[g].evt & cat_mask(cfg_q[g].cat)
                        & events[cfg_q[g].cat*EW +: EW];
                end
            end
            event_adder u_add (
                .hits(hits[g]),
                .sum(inc[g])
            );
            always_comb begin
                cfg_d[g] = cfg_q[g];
                flt_d[g] = flt_q[g];
                cnt_d[g] = cnt_q[g] + perfmon_pkg::CNT_W'(inc[g]);
                if (PRESENT && req.wr) begin
                    if (reg_idx(req.addr, perfmon_pkg::OFF_CFG0) == g) begin
                        if (!cfg_q[g].en) begin
                            cfg_d[g].cat =
                                req.wdata[perfmon_pkg::CFG_CAT_LSB +: 4];
                            cfg_d[g].evt =
                                req.wdata[perfmon_pkg::CFG_EVT_LSB +: EW];
                        end
                        cfg_d[g].en = req.wdata[perfmon_pkg::CFG_EN_BIT];
                    end
                    if (reg_idx(req.addr, perfmon_pkg::OFF_FLT0) == g
                        && !cfg_q[g].en && FILTER_SUP) begin
                        flt_d[g] = req.wdata;
                    end
                    if (reg_idx(req.addr, perfmon_pkg::OFF_DATA0) == g
                        && !cfg_q[g].en) begin
                        cnt_d[g] = req.wdata[perfmon_pkg::CNT_W-1:0];
                    end
                end
            end
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    cfg_q[g] <= CFG_INIT;
                    flt_q[g] <= perfmon_pkg::FLT_RESET;
                    cnt_q[g] <= '0;
                end else begin
                    cfg_q[g] <= cfg_d[g];
                    flt_q[g] <= flt_d[g];
                    cnt_q[g] <= cnt_d[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] perf_capability_reg;
    logic [4:0] cat_sup;
    always_comb begin
        for (int c = 0; c < perfmon_pkg::NUM_CAT; c++) begin
            cat_sup[c] = |EVCAP[c*EW +: EW];
        end
        perf_capability_reg = '0;
        if (PRESENT) begin
            perf_capability_reg[perfmon_pkg::CAP_NCNT_LSB +: 8] = 8'(N);
            perf_capability_reg[perfmon_pkg::CAP_WIDTH_LSB +: 8] = 8'(perfmon_pkg::CNT_W);
            perf_capability_reg[perfmon_pkg::CAP_PERCNT_BIT] = 1'b1;
            perf_capability_reg[perfmon_pkg::CAP_FLT_BIT] = FILTER_SUP;
            perf_capability_reg[perfmon_pkg::CAP_CAT_LSB +: 5] = cat_sup;
        end
    end

    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    int unsigned ic;
    int unsigned ie;
    always_comb begin
        rdata_d = '0;
        ic = reg_idx(req.addr, perfmon_pkg::OFF_CFG0);
        ie = 32'(req.addr - perfmon_pkg::OFF_EVCAP0) >> 2;
        if (!req.rd) begin
            rdata_d = '0;
        end else if (req.addr == perfmon_pkg::OFF_PERF_CAPABILITY_REG) begin
            rdata_d = perf_capability_reg;
        end else if (!PRESENT) begin
            rdata_d = '0;
        end else if (req.addr >= perfmon_pkg::OFF_EVCAP0
                     && req.addr < perfmon_pkg::OFF_EVCAP0
                        + 8'(4 * perfmon_pkg::NUM_CAT)
                     && req.addr[1:0] == 2'b00) begin
            rdata_d = {24'h0, cat_mask(4'(ie))};
        end else if (ic < N) begin
            rdata_d = {8'h0, cfg_q[ic].evt, 4'h0, cfg_q[ic].cat,
                       7'h0, cfg_q[ic].en};
        end else if (reg_idx(req.addr, perfmon_pkg::OFF_CNTCAP0) < N) begin
            rdata_d = CNTCAP_MASK;
        end else if (reg_idx(req.addr, perfmon_pkg::OFF_FLT0) < N) begin
            rdata_d = flt_q[reg_idx(req.addr, perfmon_pkg::OFF_FLT0)];
        end else if (reg_idx(req.addr, perfmon_pkg::OFF_DATA0) < N) begin
            rdata_d = cnt_q[reg_idx(req.addr, perfmon_pkg::OFF_DATA0)];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    property p_absent_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        !PRESENT && reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_absent_zero: assert property (p_absent_zero)
        else $error("absent read not zero");

    property p_absent_off;
        @(posedge clk_sys) disable iff (sys_rst)
        !PRESENT |-> !cfg_q[0].en && cnt_q[0] == 32'h0;
    endproperty
    a_absent_off: assert property (p_absent_off)
        else $error("absent block holds state");

    property p_cap_count;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && reg_rd && reg_addr == perfmon_pkg::OFF_PERF_CAPABILITY_REG
        |=> reg_rdata[7:0] == 8'(N);
    endproperty
    a_cap_count: assert property (p_cap_count)
        else $error("bad counter count");

    property p_rd_idle;
        @(posedge clk_sys) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not cleared");

    property p_cfg_write;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && !cfg_q[0].en && reg_wr && reg_addr == perfmon_pkg::OFF_CFG0
        |=> cfg_q[0].cat == $past(reg_wdata[perfmon_pkg::CFG_CAT_LSB +: 4])
            && cfg_q[0].evt
                == $past(reg_wdata[perfmon_pkg::CFG_EVT_LSB +: EW]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config write lost");

    property p_en_write;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && reg_wr && reg_addr == perfmon_pkg::OFF_CFG0
        |=> cfg_q[0].en == $past(reg_wdata[perfmon_pkg::CFG_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable bit not writable");

    property p_cfg_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[0].en |=> cfg_q[0].cat == $past(cfg_q[0].cat)
            && cfg_q[0].evt == $past(cfg_q[0].evt);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock)
        else $error("config changed while on");

    property p_data_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[0].en && reg_wr && reg_addr == perfmon_pkg::OFF_DATA0
        |=> cnt_q[0] == $past(cnt_q[0]) + 32'($past(inc[0]));
    endproperty
    a_data_lock: assert property (p_data_lock)
        else $error("counter written while on");

    property p_flt_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[0].en |=> flt_q[0] == $past(flt_q[0]);
    endproperty
    a_flt_lock: assert property (p_flt_lock)
        else $error("filter changed while on");

    property p_rsvd_idle;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[1].cat >= 4'h5 && !reg_wr |=> cnt_q[1] == $past(cnt_q[1]);
    endproperty
    a_rsvd_idle: assert property (p_rsvd_idle)
        else $error("reserved category counted");

    property p_rsvd_hits;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[1].cat >= 4'h5 |-> inc[1] == 4'h0;
    endproperty
    a_rsvd_hits: assert property (p_rsvd_hits)
        else $error("reserved category has hits");

    property p_sum;
        @(posedge clk_sys) disable iff (sys_rst)
        !reg_wr |=> cnt_q[0] == $past(cnt_q[0]) + 32'($past(inc[0]));
    endproperty
    a_sum: assert property (p_sum)
        else $error("counter sum wrong");

    property p_ignore;
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_q[0].en && cfg_q[0].cat < 4'h5
        |-> inc[0] <= 4'($countones(EVCAP[cfg_q[0].cat*EW +: EW]));
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("unsupported bit counted");

    property p_idle_off;
        @(posedge clk_sys) disable iff (sys_rst)
        !cfg_q[0].en |-> inc[0] == 4'h0;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("disabled counter moved");

    property p_evcap;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && reg_rd && reg_addr == perfmon_pkg::OFF_EVCAP0
        |=> reg_rdata == {24'h0, EVCAP[EW-1:0]};
    endproperty
    a_evcap: assert property (p_evcap)
        else $error("event capability wrong");

    property p_evcap_last;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && reg_rd && reg_addr == perfmon_pkg::OFF_EVCAP0
            + 8'(4 * (perfmon_pkg::NUM_CAT - 1))
        |=> reg_rdata == {24'h0, EVCAP[(perfmon_pkg::NUM_CAT - 1)*EW +: EW]};
    endproperty
    a_evcap_last: assert property (p_evcap_last)
        else $error("last category capability wrong");

    property p_cntcap;
        @(posedge clk_sys) disable iff (sys_rst)
        PRESENT && reg_rd && reg_addr == perfmon_pkg::OFF_CNTCAP0
        |=> reg_rdata == CNTCAP_MASK;
    endproperty
    a_cntcap: assert property (p_cntcap)
        else $error("per-counter capability wrong");

    c_multi: cover property (@(posedge clk_sys) inc[0] > 4'h1);
    c_locked_wr: cover property (@(posedge clk_sys)
        cfg_q[0].en && reg_wr && reg_addr == perfmon_pkg::OFF_CFG0);
    c_rsvd: cover property (@(posedge clk_sys) cfg_q[1].cat >= 4'h5);
    c_empty_cat: cover property (@(posedge clk_sys)
        cfg_q[2].en && cfg_q[2].cat == perfmon_pkg::CAT_COMPL);
    c_flt_locked: cover property (@(posedge clk_sys)
        cfg_q[0].en && reg_wr && reg_addr == perfmon_pkg::OFF_FLT0);
endmodule
`default_nettype wire

// ==== verif/perfmon_event_discovery_bench.sv ====
// Self-checking bench for the monitoring front end
`timescale 1ns/10ps
`default_nettype none
module perfmon_event_discovery_bench;
    localparam logic [39:0] EVCAP = 40'h00_0F_07_3F_FF;
    localparam logic [31:0] CNTCAP = 32'h0000_001F;
    localparam logic [39:0] ALL_EV = 40'hFF_FF_FF_FF_FF;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] exp;
    } row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [39:0] events = 40'h00_0000_0000;
    logic [31:0] reg_rdata;
    logic [31:0] rdata_off;
    int err_count = 0;
    int num_checks = 0;
    row_t rows [11];

    perfmon_event_discovery #(.PRESENT(1'b1), .EVCAP(EVCAP),
        .CNTCAP_MASK(CNTCAP)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events));

    // Same bus, monitoring absent: every read must give zero
    perfmon_event_discovery #(.PRESENT(1'b0), .EVCAP(EVCAP),
        .CNTCAP_MASK(CNTCAP)) DUT_OFF (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata_off), .events(events));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        check(rdata_off, 32'h0000_0000);
    endtask

    // Hold every event line high for n cycles, then drop them
    task automatic pulse_events(input int n);
        @(posedge clk_sys);
        events <= ALL_EV;
        repeat (n) @(posedge clk_sys);
        events <= 40'h00_0000_0000;
    endtask

    initial begin
        #(40 * 3000);
        err_count++;
        test_done();
    end

    initial begin
        rows[0] = '{8'h00, 32'h4 | (32'h20 << 8) | (32'h3 << 16)
            | (32'hF << 20)};
        for (int c = 0; c < 5; c++) begin
            rows[1 + c] = '{8'h10 + 8'(4 * c), {24'h0, EVCAP[8 * c +: 8]}};
        end
        for (int n = 0; n < 4; n++) begin
            rows[6 + n] = '{8'h40 + 8'(4 * n), CNTCAP};
        end
        rows[10] = '{8'hFC, 32'h0000_0000};
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            rd(rows[i].addr, rows[i].exp);
        end
        // Read data stand one cycle only
        @(posedge clk_sys);
        #1;
        check(reg_rdata, 32'h0000_0000);
        rd(8'h60, 32'h0000_0000);
        rd(8'hA0, 32'h0000_0000);
        // Counter 0: category 2 with unsupported mask bits set
        wr(8'h60, 32'h00FF_0201);
        pulse_events(5);
        rd(8'hA0, 32'h0000_000F);
        // Category, event, data and filter writes to enabled counter 0 are dropped, counting unchanged; the filter write to disabled counter 1 lands
        wr(8'h60, 32'h0001_0101);
        wr(8'hA0, 32'h0000_0100);
        wr(8'h80, 32'h0000_00AA);
        wr(8'h84, 32'h1234_5678);
        pulse_events(3);
        rd(8'hA0, 32'h0000_0018);
        rd(8'h60, 32'h00FF_0201);
        rd(8'h80, 32'h0000_0000);
        rd(8'h84, 32'h1234_5678);
        // Reserved category, empty category, wide mask of category 0
        wr(8'h64, 32'h00FF_0501);
        wr(8'h68, 32'h00FF_0401);
        wr(8'h6C, 32'h0081_0001);
        pulse_events(4);
        rd(8'hA0, 32'h0000_0024);
        rd(8'hA4, 32'h0000_0000);
        rd(8'hA8, 32'h0000_0000);
        rd(8'hAC, 32'h0000_0008);
        // Disable, preload, reconfigure to category 1 and wrap
        wr(8'h60, 32'h0000_0000);
        wr(8'hA0, 32'hFFFF_FFFF);
        wr(8'h60, 32'h0003_0101);
        pulse_events(1);
        rd(8'hA0, 32'h0000_0001);
        // Asynchronous reset in mid-run clears counters
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'hAC, 32'h0000_0000);
        rd(8'h6C, 32'h0000_0000);
        rd(8'h84, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
